// *** strap_loader_defines.vh ***
// Constants for the strap default loader
// Summary of operation
// RQ1: Port 2 speed low bit follows speed strap: low 10, high 100 Mbps.
// RQ2: Port 2 duplex bit follows duplex strap: low half, high full.
// RQ3: Port 2 backpressure bit follows its strap: low off, high on.
// RQ4: One strap loads both Port 2 transmit and receive pause enables.
// RQ5: Pause enables act only while fixed flow control is selected.
// RQ6: Fixed flow-control strap low clears select; negotiation result governs.
// RQ7: Fixed flow-control strap high sets select; pause enables govern.
// RQ8: Partner ability base derives from speed strap, polarity strap, duplex pin.
// RQ9: On failed virtual negotiation external port runs at strap speed.
// RQ10: External port full duplex when duplex pin equals polarity strap.
// RQ11: Straps sampled once at reset; software may override the Port 2 defaults afterwards, not the external straps.
`ifndef STRAP_LOADER_DEFINES_VH
`define STRAP_LOADER_DEFINES_VH
// Register byte offsets
`define OFS_P2_BASIC    12'h000
`define OFS_P2_FLOWCTL  12'h004
`define OFS_VPHY_LP     12'h008
`define OFS_EXT_STATUS  12'h00c
`define OFS_P2_STATUS   12'h010
// Port 2 basic control fields
`define BIT_DUPLEX      8
`define BIT_RATE_LOW    13
// Port 2 flow control fields
`define BIT_RX_PAUSE    0
`define BIT_TX_PAUSE    1
`define BIT_BACKPRESS   2
`define BIT_FIXED_FC    3
// Partner ability fields
`define BIT_LP_10HD     5
`define BIT_LP_10FD     6
`define BIT_LP_100HD    7
`define BIT_LP_100FD    8
`define LP_SELECTOR     5'h01
// External status fields
`define BIT_EXT_SPEED   0
`define BIT_EXT_DUPLEX  1
`define BIT_EXT_FAIL    2
// Port 2 status fields
`define BIT_P2_TXP      0
`define BIT_P2_RXP      1
`define SAMPLE_DELAY    2'h2
`endif

// *** port_strap_default_loader.v ***
// Strap default loader with APB register access
`timescale 1ns/1ns
`include "strap_loader_defines.vh"
module port_strap_default_loader
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        p2_speed_strap,
  input  wire        p2_duplex_strap,
  input  wire        p2_forced_collision_strap,
  input  wire        p2_pause_enable_strap,
  input  wire        p2_fixed_flowctl_strap,
  input  wire        ext_speed_strap,
  input  wire        ext_duplex_polarity_strap,
  input  wire        ext_duplex_pin,
  input  wire        ext_autoneg_fail,
  input  wire        p2_an_tx_pause,
  input  wire        p2_an_rx_pause,
  output reg         p2_tx_pause_active,
  output reg         p2_rx_pause_active,
  output reg         ext_speed_100,
  output reg         ext_full_duplex,
  output reg         straps_loaded
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [9:0] sync1_reg;
  reg [9:0] sync2_reg;
  wire [9:0] pins_in = {p2_an_rx_pause, p2_an_tx_pause, ext_autoneg_fail, ext_duplex_pin,
                        ext_duplex_polarity_strap, ext_speed_strap, p2_fixed_flowctl_strap,
                        p2_pause_enable_strap, p2_forced_collision_strap, p2_duplex_strap};
  reg        spd2_s1_reg;
  reg        spd2_s2_reg;

  // Two-stage capture of all pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg   <= 10'h000;
      sync2_reg   <= 10'h000;
      spd2_s1_reg <= 1'b0;
      spd2_s2_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_reg   <= pins_in;
      sync2_reg   <= sync1_reg;
      spd2_s1_reg <= p2_speed_strap;
      spd2_s2_reg <= spd2_s1_reg;
    end
  end

  wire s_dup2   = sync2_reg[0];
  wire s_bp2    = sync2_reg[1];
  wire s_pause2 = sync2_reg[2];
  wire s_fixed2 = sync2_reg[3];
  wire s_espd   = sync2_reg[4];
  wire s_epol   = sync2_reg[5];
  wire s_edup   = sync2_reg[6];
  wire s_efail  = sync2_reg[7];
  wire s_antx   = sync2_reg[8];
  wire s_anrx   = sync2_reg[9];

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0]  wait_reg;
  reg        loaded_reg;
  reg        phy_rate_low_bit;
  reg        bit_a;
  reg        p2_backpressure_bit;
  reg        p2_tx_pause_enable;
  reg        p2_rx_pause_enable;
  reg        p2_fixed_flowctl_select;
  reg        ext_speed_reg;
  reg        ext_pol_reg;
  reg [8:0]  vphy_ability_reg;
  wire       load_now = !loaded_reg && (wait_reg == `SAMPLE_DELAY);
  wire       wr_en    = psel && penable && pwrite;

  // Partner ability from speed, duplex match
  wire       ext_fd_now = (s_edup == ext_pol_reg);
  reg  [8:0] ability_calc;
  always @*
  begin
    ability_calc = {4'h0, `LP_SELECTOR};
    if (ext_speed_reg)
      ability_calc[`BIT_LP_100HD] = 1'b1;
    else
      ability_calc[`BIT_LP_10HD] = 1'b1;
    if (ext_fd_now && ext_speed_reg)
      ability_calc[`BIT_LP_100FD] = 1'b1;
    if (ext_fd_now && !ext_speed_reg)
      ability_calc[`BIT_LP_10FD] = 1'b1;
  end

  // Strap load once after reset, then software writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg                <= 2'h0;
      loaded_reg              <= 1'b0;
      phy_rate_low_bit        <= 1'b0;
      bit_a                   <= 1'b0;
      p2_backpressure_bit     <= 1'b0;
      p2_tx_pause_enable      <= 1'b0;
      p2_rx_pause_enable      <= 1'b0;
      p2_fixed_flowctl_select <= 1'b0;
      ext_speed_reg           <= 1'b0;
      ext_pol_reg             <= 1'b0;
      vphy_ability_reg        <= 9'h000;
    end
    else if (clk_en)
    begin
      if (!loaded_reg && wait_reg != `SAMPLE_DELAY)
        wait_reg <= wait_reg + 2'h1;
      if (load_now)
      begin
        loaded_reg <= 1'b1;
        // RQ11: single sample at reset
        // RQ1: rate low bit
        phy_rate_low_bit <= spd2_s2_reg;
        // RQ2: duplex default
        bit_a <= s_dup2;
        // RQ3: backpressure default
        p2_backpressure_bit <= s_bp2;
        // RQ4: both pause enables
        p2_tx_pause_enable <= s_pause2;
        p2_rx_pause_enable <= s_pause2;
        // RQ6: RQ7: fixed select
        p2_fixed_flowctl_select <= s_fixed2;
        ext_speed_reg <= s_espd;
        ext_pol_reg   <= s_epol;
      end
      else if (loaded_reg && wr_en)
      begin
        case (paddr)
          `OFS_P2_BASIC:
          begin
            phy_rate_low_bit <= pwdata[`BIT_RATE_LOW];
            bit_a            <= pwdata[`BIT_DUPLEX];
          end
          `OFS_P2_FLOWCTL:
          begin
            p2_rx_pause_enable      <= pwdata[`BIT_RX_PAUSE];
            p2_tx_pause_enable      <= pwdata[`BIT_TX_PAUSE];
            p2_backpressure_bit     <= pwdata[`BIT_BACKPRESS];
            p2_fixed_flowctl_select <= pwdata[`BIT_FIXED_FC];
          end
          default:
            ;
        endcase
      end
      // RQ8: ability tracks straps and pin
      if (loaded_reg)
        vphy_ability_reg <= ability_calc;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p2_tx_pause_active <= 1'b0;
      p2_rx_pause_active <= 1'b0;
      ext_speed_100      <= 1'b0;
      ext_full_duplex    <= 1'b0;
      straps_loaded      <= 1'b0;
    end
    else if (clk_en)
    begin
      // RQ5: enables used only when fixed
      p2_tx_pause_active <= p2_fixed_flowctl_select ? p2_tx_pause_enable : s_antx;
      p2_rx_pause_active <= p2_fixed_flowctl_select ? p2_rx_pause_enable : s_anrx;
      // RQ9: fallback strap speed
      if (s_efail)
        ext_speed_100 <= ext_speed_reg;
      // RQ10: pin equals polarity
      ext_full_duplex <= ext_fd_now;
      straps_loaded   <= loaded_reg;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  reg [31:0] rd_data;
  reg        rd_err;
  always @*
  begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    case (paddr)
      `OFS_P2_BASIC:
      begin
        rd_data[`BIT_RATE_LOW] = phy_rate_low_bit;
        rd_data[`BIT_DUPLEX]   = bit_a;
      end
      `OFS_P2_FLOWCTL:
      begin
        rd_data[`BIT_RX_PAUSE]  = p2_rx_pause_enable;
        rd_data[`BIT_TX_PAUSE]  = p2_tx_pause_enable;
        rd_data[`BIT_BACKPRESS] = p2_backpressure_bit;
        rd_data[`BIT_FIXED_FC]  = p2_fixed_flowctl_select;
      end
      `OFS_VPHY_LP:
        rd_data[8:0] = vphy_ability_reg;
      `OFS_EXT_STATUS:
      begin
        rd_data[`BIT_EXT_SPEED]  = ext_speed_100;
        rd_data[`BIT_EXT_DUPLEX] = ext_full_duplex;
        rd_data[`BIT_EXT_FAIL]   = s_efail;
      end
      `OFS_P2_STATUS:
      begin
        rd_data[`BIT_P2_TXP] = p2_tx_pause_active;
        rd_data[`BIT_P2_RXP] = p2_rx_pause_active;
      end
      default:
        rd_err = 1'b1;
    endcase
  end

  // One wait state: ready in second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (clk_en)
    begin
      pready  <= psel && penable && !pready && loaded_reg;
      pslverr <= psel && penable && !pready && loaded_reg && rd_err;
      if (psel && penable && !pready && !pwrite)
        prdata <= rd_data;
    end
  end

endmodule

// *** strap_pulls.sv ***
// Board resistor model driving the loader's strap pins
`timescale 1ns/1ns
module strap_pulls
(
  input  wire [6:0] pull_sel,
  output wire [6:0] strap_level
);
  // Fitted resistor sets each level; follows pull_sel whenever the bench changes it
  assign strap_level = pull_sel;
endmodule

// *** strap_loader_chk_sva.sv ***
// Port-level checker for the strap default loader
`timescale 1ns/1ns
module strap_loader_chk
(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire p2_fixed_flowctl_strap,
  input wire ext_speed_strap,
  input wire ext_duplex_polarity_strap,
  input wire ext_duplex_pin,
  input wire ext_autoneg_fail,
  input wire p2_an_tx_pause,
  input wire p2_tx_pause_active,
  input wire ext_speed_100,
  input wire ext_full_duplex,
  input wire straps_loaded
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus handshake
  stall_bus_a: assert property (!straps_loaded |-> !pready)
    else $error("ready before load");
  ready_time_a: assert property ($rose(penable) && psel && straps_loaded && clk_en |=> pready)
    else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("lone error");
  // Duplex, speed and pause outputs
  duplex_match_a: assert property ((straps_loaded && clk_en && $stable(ext_duplex_pin))[*4] |->
    ext_full_duplex == (ext_duplex_pin == ext_duplex_polarity_strap)) else $error("duplex wrong");
  fail_speed_a: assert property ((straps_loaded && clk_en && ext_autoneg_fail)[*5] |->
    ext_speed_100 == ext_speed_strap) else $error("fail speed wrong");
  speed_hold_a: assert property ((straps_loaded && !ext_autoneg_fail)[*5] |=> $stable(ext_speed_100))
    else $error("speed moved");
  neg_pause_a: assert property ((straps_loaded && clk_en && !p2_fixed_flowctl_strap && $stable(p2_an_tx_pause))[*4]
    |-> p2_tx_pause_active == p2_an_tx_pause) else $error("pause not negotiated");
  cover property (pslverr);
  cover property (ext_full_duplex && ext_speed_100);
  cover property (p2_tx_pause_active);
endmodule
bind port_strap_default_loader strap_loader_chk chk (
  .pclk                      (pclk),
  .presetn                   (presetn),
  .clk_en                    (clk_en),
  .psel                      (psel),
  .penable                   (penable),
  .pready                    (pready),
  .pslverr                   (pslverr),
  .p2_fixed_flowctl_strap    (p2_fixed_flowctl_strap),
  .ext_speed_strap           (ext_speed_strap),
  .ext_duplex_polarity_strap (ext_duplex_polarity_strap),
  .ext_duplex_pin            (ext_duplex_pin),
  .ext_autoneg_fail          (ext_autoneg_fail),
  .p2_an_tx_pause            (p2_an_tx_pause),
  .p2_tx_pause_active        (p2_tx_pause_active),
  .ext_speed_100             (ext_speed_100),
  .ext_full_duplex           (ext_full_duplex),
  .straps_loaded             (straps_loaded)
);

// *** tb_port_strap_default_loader.sv ***
// Self-checking bench for the strap default loader
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_port_strap_default_loader;
  reg         pclk = 0;
  reg         presetn = 0;
  reg         psel = 0;
  reg         penable = 0;
  reg         pwrite = 0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [6:0]  pull_sel = 7'h7f;
  reg         dpin = 0;
  reg         fail = 0;
  reg         an_p = 0;
  reg         ce = 1;
  reg  [31:0] rd;
  reg         er;
  int         errors = 0;
  int         num_checks = 0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [6:0]  lvl;
  wire        txa;
  wire        rxa;
  wire        spd100;
  wire        fdx;
  wire        loaded;
  // Clock
  always #5 pclk = ~pclk;
  strap_pulls pulls (.pull_sel(pull_sel), .strap_level(lvl));
  port_strap_default_loader uut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p2_speed_strap(lvl[0]), .p2_duplex_strap(lvl[1]),
    .p2_forced_collision_strap(lvl[2]), .p2_pause_enable_strap(lvl[3]),
    .p2_fixed_flowctl_strap(lvl[4]), .ext_speed_strap(lvl[5]), .ext_duplex_polarity_strap(lvl[6]),
    .ext_duplex_pin(dpin), .ext_autoneg_fail(fail), .p2_an_tx_pause(an_p), .p2_an_rx_pause(an_p),
    .p2_tx_pause_active(txa), .p2_rx_pause_active(rxa), .ext_speed_100(spd100), .ext_full_duplex(fdx),
    .straps_loaded(loaded));
  // One APB transfer, waits for pready
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait as long as the slave needs; the watchdog ends a hang
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // Reset with one strap pattern, then read every default
  task t_straps(input reg [6:0] p, input reg pin, input reg f);
    reg       m;
    reg [8:0] lp;
    begin
      pull_sel <= p;
      dpin <= pin;
      fail <= f;
      an_p <= ~p[3];
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(loaded, 1'b0)
      m = (pin == p[6]);
      lp = p[5] ? {m, 1'b1, 2'b00, 5'h01} : {2'b00, m, 1'b1, 5'h01};
      apb(0, 12'h000, 0);
      `CHK(rd, {18'h0, p[0], 4'h0, p[1], 8'h0})
      apb(0, 12'h004, 0);
      `CHK(rd, {28'h0, p[4], p[2], p[3], p[3]})
      apb(0, 12'h008, 0);
      `CHK(rd, {23'h0, lp})
      repeat (6) @(posedge pclk);
      apb(0, 12'h00c, 0);
      `CHK(rd, {29'h0, f, m, f & p[5]})
      apb(0, 12'h010, 0);
      `CHK(rd[1:0], {2{p[4] ? p[3] : ~p[3]}})
      `CHK({loaded, spd100, fdx}, {1'b1, f & p[5], m})
      `CHK({txa, rxa}, {2{p[4] ? p[3] : ~p[3]}})
      $display("strap pattern %h done", p);
    end
  endtask
  // Unmapped, read-only and override accesses
  task t_access;
    reg [31:0] keep;
    reg        hold;
    begin
      apb(0, 12'h020, 0);
      `CHK({er, rd}, {1'b1, 32'h0})
      apb(0, 12'h008, 0);
      keep = rd;
      apb(1, 12'h008, ~keep);
      apb(0, 12'h008, 0);
      `CHK(rd, keep)
      apb(1, 12'h000, 32'h2000);
      pull_sel[0] <= ~pull_sel[0];
      repeat (6) @(posedge pclk);
      apb(0, 12'h000, 0);
      `CHK(rd, 32'h2000)
      // Clock enable low freezes the duplex result
      hold = fdx;
      ce <= 1'b0;
      dpin <= ~dpin;
      repeat (6) @(posedge pclk);
      `CHK(fdx, hold)
      ce <= 1'b1;
      repeat (6) @(posedge pclk);
      `CHK(fdx, (dpin == pull_sel[6]))
      $display("access test done");
    end
  endtask
  // Verdict
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    $display("MISMATCH %0t watchdog expired", $time);
    errors++;
    test_done;
  end
  initial
  begin
    @(posedge pclk);
    t_straps(7'b1010101, 1'b1, 1'b1);
    t_straps(7'b0101010, 1'b1, 1'b0);
    t_straps(7'b0111100, 1'b0, 1'b1);
    t_access;
    test_done;
  end
endmodule
